// *** riag_defs.vh ***
// Constants for the radio interrupt aggregator: register offsets, field
// positions and reset values. Included by the aggregator module and its testbench.
`ifndef RIAG_DEFS_VH
`define RIAG_DEFS_VH

`define RIAG_NUM_SRC 14
`define RIAG_OFF_STATUS 6'h00
`define RIAG_OFF_MASK 6'h04
`define RIAG_OFF_CTRL 6'h08
`define RIAG_OFF_CLEAR 6'h0C
`define RIAG_OFF_ENABLE 6'h10
`define RIAG_MASK_RST 14'h3FFF
`define RIAG_CTRL_GMASK 0
`define RIAG_CTRL_PUSHPULL 1
`define RIAG_CTRL_ABORT 2
`define RIAG_CTRL_RST 3'h1
`define RIAG_SRC_UNLOCK 6
`define RIAG_STATUS_RST 14'h0000
`define RIAG_ENABLE_RST 14'h0000
`define RIAG_CTRL_W 3
`define RIAG_LANE_CTRL 0
`define RIAG_DATA_W 32

`endif

// *** riag_aggregator.v ***
// Interrupt aggregator of the radio transceiver with a classic Wishbone slave.
// Assumes event inputs come from logic on the same clock; each high cycle sets.
`timescale 1ns/1ps
`include "riag_defs.vh"

// Overview of operation
// R1 - Fourteen event inputs each feed their own pending bit.
// R2 - Unmasked pending bits are ORed onto one active-low request pin.
// R3 - Control bit selects push-pull high drive or open-drain release.
// R4 - Each pending bit is readable in the status register.
// R5 - A pending source contributes only while its mask bit is zero.
// R6 - Global mask bit blocks every request assertion when set.
// R7 - Writing one clears a status bit; zero writes and reads leave it.
// R8 - Request holds while any pending unmasked source remains and the global mask bit is clear.
// R9 - Any subset of sources may be unmasked independently.
// R10 - Synthesizer unlock aborts the sequence and sets its status bit.
// R11 - An event in the clear cycle keeps the status bit set.
// R12 - Reset clears status and sets all masks, so no request.
module riag_aggregator #(
  parameter NSRC = `RIAG_NUM_SRC
) (
  // System
  input wire clock,
  input wire rstn,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Event sources, one pulse per event
  input wire sequence_done_int,
  input wire transmit_done_int,
  input wire receive_done_int,
  input wire channel_assess_int,
  input wire receive_watermark_int,
  input wire frame_filter_reject_int,
  input wire synth_unlock_int,
  input wire wake_int,
  input wire packet_buffer_error_int,
  input wire cipher_done_int,
  input wire timer_compare_one_int,
  input wire timer_compare_two_int,
  input wire timer_compare_three_int,
  input wire timer_compare_four_int,
  // Sequencer abort on synthesizer unlock
  output reg sequence_abort,
  // Request pin, active low
  output reg irq_n_o,
  output reg irq_n_oe,
  // Status-register interrupt, active high level
  output reg status_irq
);

  // Widths of the bus and of the control field
  localparam DW = `RIAG_DATA_W;
  localparam CW = `RIAG_CTRL_W;
  // Zero padding above the source bits and above the control bits
  localparam PADW = DW - NSRC;
  localparam CPADW = DW - CW;

  // Sticky status bits and their next value
  reg [NSRC-1:0] status_reg;
  wire [NSRC-1:0] status_next;
  // Per-source pin masks, one means masked
  reg [NSRC-1:0] mask_reg;
  reg [NSRC-1:0] mask_next;
  // Per-source enables of the status interrupt, one means enabled
  reg [NSRC-1:0] enable_reg;
  reg [NSRC-1:0] enable_next;
  // Global mask, pin mode and abort enable
  reg [CW-1:0] ctrl_reg;
  reg [CW-1:0] ctrl_next;
  // Read data for the cycle that carries ack
  reg [DW-1:0] rd_data_next;

  // Per-source terms, the clear and gated ones built in the generate loop
  wire [NSRC-1:0] events;
  wire [NSRC-1:0] clear_bits;
  wire [NSRC-1:0] pending_unmasked;
  wire [NSRC-1:0] pending_enabled;
  wire [NSRC-1:0] lane_bits;
  wire [NSRC-1:0] wr_bits;

  // Bus decode
  wire bus_take;
  wire rd_take;
  wire wr_commit;
  wire hit_mask;
  wire hit_ctrl;
  wire hit_clear;
  wire hit_enable;

  // Control fields and request decode
  wire global_block;
  wire pushpull_mode;
  wire abort_enable;
  wire unlock_event;
  wire any_unmasked;
  wire any_enabled;
  wire req_active;

  // Byte-lane select spread over the source bits; upper lanes carry
  // no field, so their select bits are simply dropped
  function [NSRC-1:0] riag_lane_bits;
    input [3:0] sel;
    reg [DW-1:0] lanes;
    begin
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      riag_lane_bits = lanes[NSRC-1:0];
    end
  endfunction

  // Address match, shared by every write decode
  function riag_hit;
    input [5:0] adr;
    input [5:0] off;
    begin
      riag_hit = (adr == off);
    end
  endfunction

  // Written bits replace the old ones only on selected lanes
  function [NSRC-1:0] riag_merge;
    input [NSRC-1:0] old_val;
    input [NSRC-1:0] new_val;
    input [NSRC-1:0] lanes;
    begin
      riag_merge = (old_val & ~lanes) | (new_val & lanes);
    end
  endfunction

  // Source order fixes the status bit of each event
  assign events = {
    timer_compare_four_int,
    timer_compare_three_int,
    timer_compare_two_int,
    timer_compare_one_int,
    cipher_done_int,
    packet_buffer_error_int,
    wake_int,
    synth_unlock_int,
    frame_filter_reject_int,
    receive_watermark_int,
    channel_assess_int,
    receive_done_int,
    transmit_done_int,
    sequence_done_int
  }; // R1

  // First cycle of an access, before ack is given
  assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_take = bus_take & ~wb_we_i;
  // A write lands on the edge where the master samples ack high, so a
  // request abandoned before its ack never changes a register
  assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Register selects; the status offset takes no write at all
  assign hit_mask = riag_hit(wb_adr_i, `RIAG_OFF_MASK);
  assign hit_ctrl = riag_hit(wb_adr_i, `RIAG_OFF_CTRL);
  assign hit_clear = riag_hit(wb_adr_i, `RIAG_OFF_CLEAR);
  assign hit_enable = riag_hit(wb_adr_i, `RIAG_OFF_ENABLE);

  // Only the low source bits of the write word and lane mask matter
  assign lane_bits = riag_lane_bits(wb_sel_i);
  assign wr_bits = wb_dat_i[NSRC-1:0];

  // Control fields by name
  assign global_block = ctrl_reg[`RIAG_CTRL_GMASK];
  assign pushpull_mode = ctrl_reg[`RIAG_CTRL_PUSHPULL];
  assign abort_enable = ctrl_reg[`RIAG_CTRL_ABORT];
  assign unlock_event = events[`RIAG_SRC_UNLOCK];

  // One slice per source: clear, next status and the two gated terms
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1)
    begin : g_src
      // Clear needs a one written on a selected lane
      assign clear_bits[gi] = wr_commit & hit_clear & wr_bits[gi] & lane_bits[gi]; // R7
      // An event in the clear cycle wins, so no event is lost
      assign status_next[gi] = events[gi] | (status_reg[gi] & ~clear_bits[gi]); // R7 R11
      // Counts toward the pin only while its mask bit is zero
      assign pending_unmasked[gi] = status_reg[gi] & ~mask_reg[gi]; // R5 R9
      // Status interrupt path, independent of the pin masks
      assign pending_enabled[gi] = status_reg[gi] & enable_reg[gi];
    end
  endgenerate

  // Wide OR of the gated terms; global mask overrides every source at the pin only
  assign any_unmasked = |pending_unmasked; // R2
  assign any_enabled = |pending_enabled;
  assign req_active = any_unmasked & ~global_block; // R6 R8

  // Next values of the writable registers
  always @*
  begin
    mask_next = mask_reg;
    enable_next = enable_reg;
    ctrl_next = ctrl_reg;
    if (wr_commit && hit_mask)
    begin
      mask_next = riag_merge(mask_reg, wr_bits, lane_bits); // R9
    end
    if (wr_commit && hit_enable)
    begin
      enable_next = riag_merge(enable_reg, wr_bits, lane_bits);
    end
    // Control lives in the lowest lane only
    if (wr_commit && hit_ctrl && wb_sel_i[`RIAG_LANE_CTRL])
    begin
      ctrl_next = wb_dat_i[CW-1:0];
    end
  end

  // Status bits; reads never reach this register
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      status_reg <= `RIAG_STATUS_RST; // R12
    end
    else
    begin
      status_reg <= status_next; // R7
    end
  end

  // Masks come out of reset all set, so no request before setup
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_reg <= `RIAG_MASK_RST; // R12
    end
    else
    begin
      mask_reg <= mask_next;
    end
  end

  // Status interrupt enables
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_reg <= `RIAG_ENABLE_RST;
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  // Control starts with the global mask set and an open-drain pin
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `RIAG_CTRL_RST; // R12
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Request level; registered so decode glitches never reach the pin
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_n_o <= 1'b1; // R12
    end
    else
    begin
      irq_n_o <= ~req_active; // R2 R8
    end
  end

  // Open-drain drives only the low level, push-pull drives both;
  // released at reset so a shared line is not pulled down
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_n_oe <= 1'b0;
    end
    else
    begin
      irq_n_oe <= req_active | pushpull_mode; // R3
    end
  end

  // Level output for the status-register interrupt
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      status_irq <= 1'b0;
    end
    else
    begin
      status_irq <= any_enabled;
    end
  end

  // Abort pulse one cycle after the unlock event; software may
  // turn it off when the sequencer handles unlock itself
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sequence_abort <= 1'b0;
    end
    else
    begin
      sequence_abort <= unlock_event & abort_enable; // R10
    end
  end

  // Read data picked while the access is taken; zero when idle so an
  // OR of several slaves on the bus stays clean
  always @*
  begin
    rd_data_next = {DW{1'b0}};
    if (rd_take)
    begin
      case (wb_adr_i)
        `RIAG_OFF_STATUS: rd_data_next = {{PADW{1'b0}}, status_reg}; // R4
        `RIAG_OFF_MASK: rd_data_next = {{PADW{1'b0}}, mask_reg};
        `RIAG_OFF_CTRL: rd_data_next = {{CPADW{1'b0}}, ctrl_reg};
        `RIAG_OFF_ENABLE: rd_data_next = {{PADW{1'b0}}, enable_reg};
        default: rd_data_next = {DW{1'b0}};
      endcase
    end
  end

  // One-cycle ack for every access, mapped or not
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_take;
    end
  end

  // Read data stands only in the ack cycle
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_dat_o <= {DW{1'b0}};
    end
    else
    begin
      wb_dat_o <= rd_data_next;
    end
  end
endmodule // riag_aggregator

// *** riag_chk.sv ***
// Checker on the aggregator ports.
// Bound into every aggregator instance.
`timescale 1ns/1ps
module riag_chk #(parameter NSRC = 14) (
  // Bus and pins
  input wire clock, rstn, wb_cyc_i, wb_stb_i, wb_ack_o, synth_unlock_int, sequence_abort,
  input wire irq_n_o, irq_n_oe, status_irq,
  input wire [31:0] wb_dat_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Bus timing, then pin and status behaviour
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
  pin_drive_a: assert property (!irq_n_o |-> irq_n_oe) else $error("low not driven");
  abort_src_a: assert property (sequence_abort |-> $past(synth_unlock_int))
    else $error("stray abort");
  rise_cause_a: assert property ($rose(irq_n_o) |-> $past(wb_ack_o, 2))
    else $error("request dropped");
  reset_quiet_a: assert property (!$past(rstn) |-> irq_n_o && !status_irq)
    else $error("request at reset");
  cover property ($fell(irq_n_o));
  cover property (sequence_abort);
  cover property ($rose(status_irq));
endmodule // riag_chk
bind riag_aggregator riag_chk #(.NSRC(NSRC)) u_chk(.*);

// *** riag_mcu.sv ***
// Microcontroller side of the request pin.
// Assumes a board pull-up on the line.
`timescale 1ns/1ps
module riag_mcu (
  // Pin from the aggregator
  input wire irq_n_o,
  input wire irq_n_oe,
  // Level seen by the microcontroller
  output wire irq_pin
);
  // Released line floats up, never keeps the last level
  assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
endmodule // riag_mcu

// *** riag_aggregator_tb.sv ***
// Testbench for the aggregator with a microcontroller pin model.
// Assumes the one-cycle Wishbone answer of the slave.
`timescale 1ns/1ps
`include "riag_defs.vh"
module riag_aggregator_tb;
  reg clock = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  reg [5:0] adr = 0;
  reg [31:0] dat = 0, r;
  reg [13:0] ev = 0;
  reg [3:0] sel = 4'hF;
  wire [31:0] rdat;
  wire ack, irq_n, oe, sirq, abrt, pin;
  integer miscompares = 0, n_checks = 0, i;
  // Clock
  always #5 clock = ~clock;
  riag_aggregator u_dut(.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sequence_done_int(ev[0]), .transmit_done_int(ev[1]),
    .receive_done_int(ev[2]), .channel_assess_int(ev[3]), .receive_watermark_int(ev[4]),
    .frame_filter_reject_int(ev[5]), .synth_unlock_int(ev[6]), .wake_int(ev[7]),
    .packet_buffer_error_int(ev[8]), .cipher_done_int(ev[9]), .timer_compare_one_int(ev[10]),
    .timer_compare_two_int(ev[11]), .timer_compare_three_int(ev[12]),
    .timer_compare_four_int(ev[13]), .sequence_abort(abrt), .irq_n_o(irq_n), .irq_n_oe(oe),
    .status_irq(sirq));
  riag_mcu u_mcu(.irq_n_o(irq_n), .irq_n_oe(oe), .irq_pin(pin));
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // One classic cycle; held until ack is sampled
  task wb(input w, input [5:0] a, input [31:0] d);
    begin
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      r = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clock);
    end
  endtask
  task pulse(input [13:0] m);
    begin
      ev <= m;
      @(posedge clock);
      ev <= 14'h0;
      @(posedge clock);
      chk(abrt, m[6]);
    end
  endtask
  task t_reset;
    begin
      wb(0, `RIAG_OFF_MASK, 0);
      chk(r, 32'h3FFF);
      chk(pin, 1);
    end
  endtask
  task t_src;
    begin
      wb(1, `RIAG_OFF_MASK, 0);
      wb(1, `RIAG_OFF_CTRL, 32'h4);
      for (i = 0; i < 14; i = i + 1)
      begin
        pulse(14'h1 << i);
        wb(0, `RIAG_OFF_STATUS, 0);
        chk(r, 32'h1 << i);
        chk(pin, 0);
        wb(1, `RIAG_OFF_CLEAR, 0);
        wb(0, `RIAG_OFF_STATUS, 0);
        chk(r, 32'h1 << i);
        wb(1, `RIAG_OFF_CLEAR, 32'h1 << i);
        @(posedge clock);
        chk(pin, 1);
      end
    end
  endtask
  task t_mask;
    begin
      wb(1, `RIAG_OFF_MASK, 32'h3FFE);
      pulse(14'h3FFE);
      @(posedge clock);
      chk(pin, 1);
      pulse(14'h1);
      @(posedge clock);
      chk(pin, 0);
      wb(1, `RIAG_OFF_CTRL, 32'h5);
      @(posedge clock);
      chk(pin, 1);
      wb(1, `RIAG_OFF_ENABLE, 32'h2000);
      @(posedge clock);
      chk(sirq, 1);
      wb(1, `RIAG_OFF_CLEAR, 32'h3FFF);
      @(posedge clock);
      chk(sirq, 0);
    end
  endtask
  // Push-pull idle drive, lane select, and a clear that meets its event
  task t_mode;
    begin
      wb(1, `RIAG_OFF_CTRL, 32'h6);
      @(posedge clock);
      chk(oe, 1);
      chk(pin, 1);
      sel <= 4'h1;
      wb(1, `RIAG_OFF_MASK, 0);
      sel <= 4'hF;
      wb(0, `RIAG_OFF_MASK, 0);
      chk(r, 32'h3F00);
      pulse(14'h2);
      @(posedge clock);
      chk(pin, 0);
      // Event held up to the ack edge of the clear, dropped right after
      ev <= 14'h2;
      {cyc, stb, we, adr, dat} <= {2'b11, 1'b1, `RIAG_OFF_CLEAR, 32'h2};
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      {cyc, stb} <= 2'b00;
      ev <= 14'h0;
      @(posedge clock);
      wb(0, `RIAG_OFF_STATUS, 0);
      chk(r, 32'h2);
      chk(pin, 0);
    end
  endtask
  // Mid-run reset with a request pending
  task t_rerst;
    begin
      rstn <= 0;
      repeat (2) @(posedge clock);
      chk(pin, 1);
      chk(oe, 0);
      rstn <= 1;
      @(posedge clock);
      wb(0, `RIAG_OFF_STATUS, 0);
      chk(r, 0);
      wb(0, `RIAG_OFF_MASK, 0);
      chk(r, 32'h3FFF);
      wb(0, `RIAG_OFF_CTRL, 0);
      chk(r, 32'h1);
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Watchdog far beyond the few hundred cycles needed
  initial
  begin
    #50000;
    miscompares = miscompares + 1;
    final_report;
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    t_reset;
    t_src;
    t_mask;
    t_mode;
    t_rerst;
    final_report;
  end
endmodule // riag_aggregator_tb
